// ### design/gxp_core.sv
// Purpose: Eight-pin port expander core behind a two-wire serial slave
// Assumes: scl and sda sampled by clk_sys, far faster than the bus clock
// Notes:   Open-drain lines use a low-active enable; pad resolves level
`default_nettype none
`include "gxp_defs.svh"

module gxp_core (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       ce,
   input  wire logic       sclIn,
   input  wire logic       sdaIn,
   output logic            sdaOut,
   output logic            sdaOeN,
   input  wire logic       addrSelectBit0,
   input  wire logic       addrSelectBit1,
   input  wire logic       addrSelectBit2,
   input  wire logic [7:0] portPinsIn,
   output logic [7:0]      portPinsOut,
   output logic [7:0]      portPinsOeN,
   output logic [7:0]      highSideDriver,
   output logic [7:0]      lowSideDriver,
   output logic            alertOut,
   output logic            alertOeN
);
   import gxp_pkg::*;

   gxp_pins_t rawPins;
   gxp_pins_t pinS;
   gxp_core_t q;
   gxp_core_t d;
   logic      sclRise;
   logic      sclFall;
   logic      startCond;
   logic      stopCond;
   logic      addrHit;

   // Gather asynchronous pins into one carrier
   assign rawPins = '{scl: sclIn, sda: sdaIn,
                      addrSel: {addrSelectBit2, addrSelectBit1,
                                addrSelectBit0},
                      port: portPinsIn};

   // Every outside level passes two flops first
   gxp_sync u_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .ce      (ce),
      .pinsIn  (rawPins),
      .pinsOut (pinS)
   );

   // Register readback; input register shows polarity-adjusted capture
   function automatic logic [7:0] regRead(input logic [1:0] sel,
                                          input gxp_core_t s);
      logic [7:0] v;
      v = 8'h00;
      case (sel)
         `GXP_SEL_IN:  v = s.inCap ^ s.polReg;
         `GXP_SEL_OUT: v = s.outReg;
         `GXP_SEL_POL: v = s.polReg;
         `GXP_SEL_CFG: v = s.cfgReg;
         default:      v = 8'h00;
      endcase
      return v;
   endfunction

   // True when the input register is the target; both read acks
   // refresh the capture through this one decode
   function automatic logic inputSel(input logic [1:0] sel);
      return (sel == `GXP_SEL_IN);
   endfunction

   // Ack phases in which the slave pulls sda low
   function automatic logic ackPhase(input gxp_state_t st);
      logic a;
      a = 1'b0;
      case (st)
         GXP_AACK: a = 1'b1;
         GXP_RACK: a = 1'b1;
         default:  a = 1'b0;
      endcase
      return a;
   endfunction

   // Driver decode per pin: only output pins turn a device on,
   // so an input pin stays high impedance whatever its output bit
   function automatic logic [7:0] drvDecode(input logic [7:0] cfg,
                                            input logic [7:0] val,
                                            input logic       high);
      logic [7:0] on;
      on = 8'h00;
      for (int i = 0; i < 8; i++) begin
         if (!cfg[i]) begin
            on[i] = high ? val[i] : ~val[i];
         end
      end
      return on;
   endfunction

   // Bus edges and conditions from the synchronised lines
   assign sclRise   = pinS.scl & ~q.sclPrev;
   assign sclFall   = ~pinS.scl & q.sclPrev;
   assign startCond = pinS.scl & q.sclPrev & q.sdaPrev & ~pinS.sda;
   assign stopCond  = pinS.scl & q.sclPrev & ~q.sdaPrev & pinS.sda;
   // Address byte match, select pins give the low bits
   assign addrHit   = (q.shift[7:4] == `GXP_ADDR_HI) &&
                      (q.shift[3:1] == pinS.addrSel);

   // Next-state logic for the whole core
   always_comb begin
      d         = q;
      d.sclPrev = pinS.scl;
      d.sdaPrev = pinS.sda;

      // First sample after reset becomes the input capture
      if (!q.primed) begin
         d.inCap  = pinS.port;
         d.primed = 1'b1;
      end

      // Start and stop win over any bit activity
      if (startCond) begin
         d.st     = GXP_ADDR;
         d.bitCnt = `GXP_BIT_FIRST;
         d.full   = 1'b0;
      end else if (stopCond) begin
         d.st     = GXP_IDLE;
         d.full   = 1'b0;
      end else begin
         case (q.st)
            GXP_IDLE: begin
               d.st = GXP_IDLE;
            end
            // Shift address and command/data bytes in on rising scl
            GXP_ADDR, GXP_RXB: begin
               if (sclRise && !q.full) begin
                  d.shift  = {q.shift[6:0], pinS.sda};
                  d.bitCnt = q.bitCnt + 3'h1;
                  d.full   = (q.bitCnt == `GXP_BIT_LAST);
               end else if (sclFall && q.full) begin
                  d.full = 1'b0;
                  if (q.st == GXP_ADDR) begin
                     // Foreign address: drop out, registers untouched
                     if (addrHit) begin
                        d.st        = GXP_AACK;
                        d.rw        = q.shift[0];
                        d.firstByte = 1'b1;
                     end else begin
                        d.st = GXP_IDLE;
                     end
                  end else begin
                     d.st = GXP_RACK;
                     if (q.firstByte) begin
                        // Command byte picks the target register
                        d.ptr       = q.shift[1:0];
                        d.firstByte = 1'b0;
                     end else begin
                        // Data byte; input register ignores writes
                        case (q.ptr)
                           `GXP_SEL_OUT: d.outReg = q.shift;
                           `GXP_SEL_POL: d.polReg = q.shift;
                           `GXP_SEL_CFG: d.cfgReg = q.shift;
                           default:      d.outReg = q.outReg;
                        endcase
                     end
                  end
               end
            end
            // Address ack; an input read refreshes capture and clears
            GXP_AACK: begin
               if (sclRise && q.rw == `GXP_RW_READ &&
                   inputSel(q.ptr)) begin
                  d.inCap = pinS.port;
               end
               if (sclFall) begin
                  d.bitCnt = `GXP_BIT_FIRST;
                  if (q.rw == `GXP_RW_READ) begin
                     d.st    = GXP_TXB;
                     d.shift = regRead(q.ptr, q);
                  end else begin
                     d.st = GXP_RXB;
                  end
               end
            end
            // Write ack ends on the falling edge
            GXP_RACK: begin
               if (sclFall) begin
                  d.st     = GXP_RXB;
                  d.bitCnt = `GXP_BIT_FIRST;
               end
            end
            // Shift out on falling scl, msb first
            GXP_TXB: begin
               if (sclFall) begin
                  d.shift  = {q.shift[6:0], 1'b0};
                  d.bitCnt = q.bitCnt + 3'h1;
                  if (q.bitCnt == `GXP_BIT_LAST) begin
                     d.st = GXP_TACK;
                  end
               end
            end
            // Master ack; next input byte clears the alert here
            GXP_TACK: begin
               if (sclRise) begin
                  d.mAck = ~pinS.sda;
                  if (!pinS.sda && inputSel(q.ptr)) begin
                     d.inCap = pinS.port;
                  end
               end
               if (sclFall) begin
                  d.bitCnt = `GXP_BIT_FIRST;
                  if (q.mAck) begin
                     d.st    = GXP_TXB;
                     d.shift = regRead(q.ptr, d);
                  end else begin
                     // Nack: release the bus and wait for stop
                     d.st = GXP_IDLE;
                  end
               end
            end
            default: begin
               d.st = GXP_IDLE;
            end
         endcase
      end

      // Alert: any input pin differing from capture, either edge
      // A change in the clearing cycle is absorbed by the new capture
      d.intPend = |((pinS.port ^ d.inCap) & d.cfgReg);
      d.intOeN  = ~d.intPend;

      // Drive sda low for acks and for zero data bits
      // Taken from next state so the line moves with the state change
      d.sdaOeN = ~(ackPhase(d.st) ||
                   (d.st == GXP_TXB && !d.shift[7]));

      // Pin drivers: input pins float, outputs follow output register
      // Both devices are never on together, so no shoot-through path
      d.portOut = d.outReg;
      d.portOeN = d.cfgReg;
      d.hiDrv   = drvDecode(d.cfgReg, d.outReg, 1'b1);
      d.loDrv   = drvDecode(d.cfgReg, d.outReg, 1'b0);
   end

   // Single register stage for all state, frozen while ce is low
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         // Released bus lines and all pins inputs until reprogrammed
         q <= '{st:        GXP_IDLE,
                bitCnt:    `GXP_BIT_FIRST,
                full:      1'b0,
                shift:     8'h00,
                rw:        1'b0,
                firstByte: 1'b0,
                mAck:      1'b0,
                ptr:       `GXP_SEL_IN,
                outReg:    `GXP_OUT_RST,
                polReg:    `GXP_POL_RST,
                cfgReg:    `GXP_CFG_RST,
                inCap:     8'h00,
                primed:    1'b0,
                sclPrev:   1'b1,
                sdaPrev:   1'b1,
                intPend:   1'b0,
                sdaOeN:    1'b1,
                intOeN:    1'b1,
                portOut:   `GXP_OUT_RST,
                portOeN:   `GXP_CFG_RST,
                hiDrv:     8'h00,
                loDrv:     8'h00};
      end else if (ce) begin
         q <= d;
      end
   end

   // Open-drain lines only ever pull low
   assign sdaOut         = 1'b0;
   assign alertOut       = 1'b0;
   assign sdaOeN         = q.sdaOeN;
   assign alertOeN       = q.intOeN;
   assign portPinsOut    = q.portOut;
   assign portPinsOeN    = q.portOeN;
   assign highSideDriver = q.hiDrv;
   assign lowSideDriver  = q.loDrv;

endmodule

`default_nettype wire

// ### design/gxp_defs.svh
// Purpose: Named constants for the serial-controlled eight-pin port core
// Assumes: Included by the package and by every design file
// Notes:   Definitions only, guarded against double inclusion
`ifndef GXP_DEFS_SVH
`define GXP_DEFS_SVH

// Fixed upper nibble of the seven-bit slave address
`define GXP_ADDR_HI    4'h4
// Register selectors carried in the low two command bits
`define GXP_SEL_IN     2'h0
`define GXP_SEL_OUT    2'h1
`define GXP_SEL_POL    2'h2
`define GXP_SEL_CFG    2'h3
// Register values after reset
`define GXP_OUT_RST    8'hFF
`define GXP_POL_RST    8'h00
`define GXP_CFG_RST    8'hFF
// Bit counter values
`define GXP_BIT_FIRST  3'h0
`define GXP_BIT_LAST   3'h7
// Read/write flag value meaning read
`define GXP_RW_READ    1'b1

`endif

// ### design/gxp_pkg.sv
// Purpose: Types shared by the port core and its pin synchroniser
// Assumes: gxp_defs.svh holds every macro constant; state codes are in the enum below
// Notes:   States use Gray codes along the usual transfer path
`default_nettype none
`include "gxp_defs.svh"

package gxp_pkg;

   // Serial slave states
   typedef enum logic [2:0] {
      GXP_IDLE = 3'h0,
      GXP_ADDR = 3'h1,
      GXP_AACK = 3'h3,
      GXP_RXB  = 3'h2,
      GXP_RACK = 3'h6,
      GXP_TXB  = 3'h7,
      GXP_TACK = 3'h5
   } gxp_state_t;

   // All levels arriving from outside the clock domain
   typedef struct packed {
      logic       scl;
      logic       sda;
      logic [2:0] addrSel;
      logic [7:0] port;
   } gxp_pins_t;

   // Synchroniser state: two stages
   typedef struct packed {
      gxp_pins_t s1;
      gxp_pins_t s2;
   } gxp_sync_t;

   // Complete core state
   typedef struct packed {
      gxp_state_t st;
      logic [2:0] bitCnt;
      logic       full;
      logic [7:0] shift;
      logic       rw;
      logic       firstByte;
      logic       mAck;
      logic [1:0] ptr;
      logic [7:0] outReg;
      logic [7:0] polReg;
      logic [7:0] cfgReg;
      logic [7:0] inCap;
      logic       primed;
      logic       sclPrev;
      logic       sdaPrev;
      logic       intPend;
      logic       sdaOeN;
      logic       intOeN;
      logic [7:0] portOut;
      logic [7:0] portOeN;
      logic [7:0] hiDrv;
      logic [7:0] loDrv;
   } gxp_core_t;

endpackage

`default_nettype wire

// ### design/gxp_sync.sv
// Purpose: Two-stage synchroniser for every pin entering the core
// Assumes: Inputs are asynchronous to clk_sys
// Notes:   First stage feeds only the second stage
`default_nettype none
`include "gxp_defs.svh"

module gxp_sync (
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire gxp_pkg::gxp_pins_t pinsIn,
   output var  gxp_pkg::gxp_pins_t pinsOut
);
   import gxp_pkg::*;

   gxp_sync_t q;
   gxp_sync_t d;

   // Shift both stages; idle bus levels after reset
   always_comb begin
      d    = q;
      d.s1 = pinsIn;
      d.s2 = q.s1;
   end

   // Reset to released bus lines so no false start is seen
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         q <= '{s1: '{scl: 1'b1, sda: 1'b1, addrSel: 3'h0, port: 8'h00},
                s2: '{scl: 1'b1, sda: 1'b1, addrSel: 3'h0, port: 8'h00}};
      end else if (ce) begin
         q <= d;
      end
   end

   assign pinsOut = q.s2;

endmodule

`default_nettype wire

// ### verif/gxp_i2c_master.sv
// Purpose: Two-wire bus master model driving the port core's serial pins
// Assumes: Tasks entered just after a clk_sys falling edge, 48 ns bit time
// Notes:   Released SDA reads as the pull-up level; SCL idles high
`default_nettype none

module gxp_i2c_master (
   output logic      scl,
   output logic      sda,
   input  wire logic sdaBus
);
   timeunit 1ns;
   timeprecision 1ns;

   // Bus idle at time zero, clock stands still outside frames
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end

   // Long low phase first so a slave ack is gone before SCL rises
   task automatic start();
      sda = 1'b1;
      #24 scl = 1'b1;
      #12 sda = 1'b0;
      #12 scl = 1'b0;
   endtask

   // Data low, clock high, then data rises while clock is high
   task automatic stop();
      sda = 1'b0;
      #24 scl = 1'b1;
      #12 sda = 1'b1;
      #24;
   endtask

   // Nine bits, msb first; a one releases the line for the slave
   task automatic byteIo(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         #12 sda = tx[i];
         #12 scl = 1'b1;
         #20 rx[i] = sdaBus;
         #4 scl = 1'b0;
      end
   endtask
endmodule

`default_nettype wire

// ### verif/gxp_core_properties.sv
// Purpose: Port-level checks of drivers, alert and serial answer timing
// Assumes: Bench keeps pins quiet around reset release
// Notes:   Attached to every port core instance by bind
`default_nettype none

module gxp_core_properties (
   input wire logic       clk_sys,
   input wire logic       rst,
   input wire logic       sclIn,
   input wire logic       sdaOut,
   input wire logic       sdaOeN,
   input wire logic [7:0] portPinsIn,
   input wire logic [7:0] portPinsOut,
   input wire logic [7:0] portPinsOeN,
   input wire logic [7:0] highSideDriver,
   input wire logic [7:0] lowSideDriver,
   input wire logic       alertOut,
   input wire logic       alertOeN
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   // Six cycles with no pin or direction movement
   sequence pinsQuiet;
      ($stable(portPinsIn) && $stable(portPinsOeN)) [*6];
   endsequence

   // Driver pairs follow direction and output value
   a_in_hiz: assert property (
      (portPinsOeN & (highSideDriver | lowSideDriver)) == 8'h00)
      else $error("driver on for an input pin");
   a_out_drive: assert property ((~portPinsOeN & ((highSideDriver ^
      portPinsOut) | (lowSideDriver ^ ~portPinsOut))) == 8'h00)
      else $error("output pin driver mismatch");
   // Alert falls only for a cause at the pins, clears at an ack
   // Window reaches the fall cycle: a direction write moves both at once
   a_alert_cause: assert property (
      pinsQuiet ##1 ($stable(portPinsIn) && $stable(portPinsOeN))
      |-> !$fell(alertOeN))
      else $error("alert raised without pin change");
   a_alert_clear: assert property (
      pinsQuiet ##0 $rose(alertOeN) |-> sclIn)
      else $error("alert cleared outside clock high");
   // Serial answer moves only while the bus clock is low
   a_sda_scl_low: assert property (
      $changed(sdaOeN) |-> !$past(sclIn) && !sclIn)
      else $error("sda changed with clock high");
   a_ack_hold: assert property ($fell(sdaOeN) |=> !sdaOeN [*7])
      else $error("sda low too short");
   a_out_update: assert property ($changed(portPinsOut) |-> !sclIn)
      else $error("output value changed with clock high");
   a_dir_update: assert property ($changed(portPinsOeN) |-> !sclIn)
      else $error("direction changed with clock high");
   a_open_drain: assert property (!sdaOut && !alertOut)
      else $error("open drain value not low");
endmodule

bind gxp_core gxp_core_properties u_props (.clk_sys(clk_sys), .rst(rst),
   .sclIn(sclIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
   .portPinsIn(portPinsIn), .portPinsOut(portPinsOut),
   .portPinsOeN(portPinsOeN), .highSideDriver(highSideDriver),
   .lowSideDriver(lowSideDriver), .alertOut(alertOut),
   .alertOeN(alertOeN));

`default_nettype wire

// ### verif/tb_top.sv
// Purpose: Directed bench for the port core through its serial bus
// Assumes: Bus master model owns SCL and the master side of SDA
// Notes:   Pins resolve from core drive and bench levels
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import gxp_pkg::*;

   logic       clk_sys, rst, sclM, sdaM, sdaBus, ak;
   logic       sdaOut, sdaOeN, alertOut, alertOeN;
   logic [2:0] addrSel;
   logic [7:0] ext, pins, d, pOut, pOeN, hiDrv, loDrv;
   logic [7:0] rstVal [4] = '{8'h00, 8'hFF, 8'h00, 8'hFF};
   int         mismatches = 0;
   int         cmp_count = 0;

   // Pull-up on SDA; driven pins show the core, others the bench
   assign sdaBus = sdaM & sdaOeN;
   assign pins = (~pOeN & pOut) | (pOeN & ext);

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   gxp_i2c_master u_mst (.scl(sclM), .sda(sdaM), .sdaBus(sdaBus));

   gxp_core u_dut (.clk_sys(clk_sys), .rst(rst), .ce(1'b1),
      .sclIn(sclM), .sdaIn(sdaBus), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
      .addrSelectBit0(addrSel[0]), .addrSelectBit1(addrSel[1]),
      .addrSelectBit2(addrSel[2]), .portPinsIn(pins),
      .portPinsOut(pOut), .portPinsOeN(pOeN), .highSideDriver(hiDrv),
      .lowSideDriver(loDrv), .alertOut(alertOut), .alertOeN(alertOeN));

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Synchroniser and register latency, plus margin
   task automatic settle();
      repeat (6) @(negedge clk_sys);
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] c,
                     input logic [7:0] v);
      logic [8:0] rx;
      u_mst.start();
      u_mst.byteIo({a, 1'b0, 1'b1}, rx);
      ak = ~rx[0];
      u_mst.byteIo({c, 1'b1}, rx);
      u_mst.byteIo({v, 1'b1}, rx);
      u_mst.stop();
      settle();
   endtask

   // Optional pointer set, repeated start, one byte closed by nack
   task automatic rd(input logic [6:0] a, input logic setPtr,
                     input logic [7:0] c);
      logic [8:0] rx;
      if (setPtr) begin
         u_mst.start();
         u_mst.byteIo({a, 1'b0, 1'b1}, rx);
         u_mst.byteIo({c, 1'b1}, rx);
      end
      u_mst.start();
      u_mst.byteIo({a, 1'b1, 1'b1}, rx);
      ak = ~rx[0];
      u_mst.byteIo(9'h1FF, rx);
      d = rx[8:1];
      u_mst.stop();
      settle();
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Whole sequence needs well under this
   initial begin
      #200000;
      mismatches++;
      give_verdict();
   end

   initial begin
      rst = 1'b1;
      ext = 8'h00;
      addrSel = 3'h0;
      repeat (8) @(negedge clk_sys);
      rst = 1'b0;
      repeat (8) @(negedge clk_sys);
      chk(pOeN, 8'hFF);
      chk(hiDrv | loDrv, 8'h00);
      chk(pOut, 8'hFF);
      chk(alertOeN, 1'b1);
      for (int i = 1; i < 4; i++) begin
         rd(7'h20, 1'b1, i[7:0]);
         chk(d, rstVal[i]);
      end
      wr(7'h20, 8'h03, 8'h0F);
      chk(ak, 1'b1);
      chk(pOeN, 8'h0F);
      wr(7'h20, 8'h01, 8'hA5);
      chk(hiDrv, 8'hA0);
      chk(loDrv, 8'h50);
      chk(alertOeN, 1'b1);
      wr(7'h20, 8'h02, 8'h01);
      ext = 8'h03;
      settle();
      chk(alertOeN, 1'b0);
      rd(7'h20, 1'b1, 8'h00);
      chk(d, 8'hA2);
      chk(alertOeN, 1'b1);
      ext = 8'h01;
      settle();
      chk(alertOeN, 1'b0);
      wr(7'h27, 8'h01, 8'h00);
      chk(ak, 1'b0);
      chk(alertOeN, 1'b0);
      chk(pOut, 8'hA5);
      ext = 8'h03;
      settle();
      chk(alertOeN, 1'b1);
      rd(7'h20, 1'b1, 8'h03);
      rd(7'h20, 1'b0, 8'h00);
      chk(d, 8'h0F);
      wr(7'h20, 8'h03, 8'hFF);
      chk(alertOeN, 1'b0);
      chk(hiDrv | loDrv, 8'h00);
      addrSel = 3'h5;
      settle();
      rd(7'h25, 1'b1, 8'h00);
      chk(d, 8'h02);
      chk(alertOeN, 1'b1);
      wr(7'h20, 8'h01, 8'h00);
      chk(ak, 1'b0);
      // Pins low first so the fresh capture matches them
      ext = 8'h00;
      settle();
      rst = 1'b1;
      repeat (2) @(negedge clk_sys);
      rst = 1'b0;
      repeat (8) @(negedge clk_sys);
      chk(pOut, 8'hFF);
      give_verdict();
   end
endmodule

`default_nettype wire
